// ==== common/rc_tx_pkg.sv ====
/* Constants, types and register map of the rolling-code line encoder.
   Assumes a 10 MHz core clock and an APB master with 32-bit data. */
`default_nettype none
package rc_tx_pkg;
   // ****************************************
   // Timing
   // ****************************************
   localparam int unsigned CLK_HZ = 10_000_000;
   localparam int unsigned HOLD_TIMEOUT_S = 80;
   localparam int unsigned HOLD_TIMEOUT_CYCLES = HOLD_TIMEOUT_S * CLK_HZ;
   // Sub-intervals of one coding period and waveform break points
   localparam logic [5:0] SUBS = 6'h0C;
   localparam logic [5:0] CELL_IR_ONE = 6'h18;
   localparam logic [5:0] CELL_IR_ZERO = 6'h24;
   localparam logic [5:0] SUB_HALF = 6'h06;
   localparam logic [5:0] SUB_THIRD = 6'h04;
   localparam logic [5:0] SUB_2THIRD = 6'h08;
   localparam logic [5:0] SUB_QTR = 6'h03;
   localparam logic [5:0] SUB_LOW1 = 6'h02;
   localparam logic [5:0] SUB_LOW0 = 6'h01;
   localparam logic [11:0] IR_MASK [4] = '{12'hAAA, 12'h924, 12'hDB6, 12'h888};
   // ****************************************
   // Formats and field lengths
   // ****************************************
   localparam logic [3:0] FMT_RF0 = 4'h0;
   localparam logic [3:0] FMT_RF1 = 4'h1;
   localparam logic [3:0] FMT_RF2 = 4'h2;
   localparam logic [3:0] FMT_RF3 = 4'h3;
   localparam logic [3:0] FMT_RF4 = 4'h4;
   localparam logic [3:0] FMT_RF5 = 4'h5;
   localparam logic [3:0] FMT_RSVD = 4'h6;
   localparam logic [3:0] FMT_RF7 = 4'h7;
   localparam logic [5:0] LEN_PRE = 6'h0B;
   localparam logic [5:0] LEN_BYTE = 6'h08;
   localparam logic [5:0] LEN_KEYID_L = 6'h18;
   localparam logic [5:0] LEN_KEYID_S = 6'h14;
   localparam logic [5:0] LEN_DATA = 6'h04;
   localparam logic [5:0] LEN_DYN_S = 6'h18;
   localparam logic [5:0] LEN_DYN_L = 6'h24;
   localparam logic [5:0] LEN_START = 6'h28;
   localparam logic [5:0] LEN_STOP = 6'h01;
   // ****************************************
   // Register map
   // ****************************************
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_PERIOD = 8'h04;
   localparam logic [7:0] ADDR_PAUSE = 8'h08;
   localparam logic [7:0] ADDR_KEYID = 8'h0C;
   localparam logic [7:0] ADDR_SYNCPAR = 8'h10;
   localparam logic [7:0] ADDR_DYN_LO = 8'h14;
   localparam logic [7:0] ADDR_DYN_HI = 8'h18;
   localparam logic [7:0] ADDR_STATUS = 8'h1C;
   localparam logic [15:0] CTRL_RST = 16'h0000;
   localparam logic [15:0] PERIOD_RST = 16'h0010;
   localparam logic [15:0] PAUSE_RST = 16'h0060;
   typedef struct packed {
      logic sync_mode;
      logic parity_en;
      logic dyn36;
      logic keyid24;
      logic keyid_en;
      logic sync_nrz;
      logic sync_en;
      logic preamble_en;
      logic hold_timeout_enable;
      logic rc_clock;
      logic indicator_pin_select;
      logic transmit_polarity;
      logic [3:0] fmt;
   } ctrl_t;
   typedef enum logic [2:0] {
      FLD_PRE, FLD_SYNC, FLD_KEYID, FLD_DATA, FLD_DYN, FLD_PAR, FLD_STOP
   } field_t;
   typedef enum logic [1:0] {ST_IDLE, ST_FRAME, ST_PAUSE, ST_HALT} state_t;
   typedef enum logic [1:0] {KIND_CODED, KIND_NRZ, KIND_RAW} kind_t;
endpackage : rc_tx_pkg
`default_nettype wire

// ==== verilog/rolling_code_tx_line_encoder.sv ====
/* Line encoder of a rolling-code key transmitter: frame sequencer, eleven
   bit coding formats, pin muxing, APB register file.
   Assumes keys are raw active-low pins and the frame contents are loaded by
   software before a key is pressed. */
// Chosen here: the register offsets and the APB slave port.
`default_nettype none
// Function
// - Pin roles follow clock type and select
// - Indicator on in pause, RF enable in frame
// - Four select bits choose RF or IR format
// - Code 6 and IR with bit2 reserved
// - RF format 0 is Manchester, data XOR clock
// - RF formats 0 and 2 DC balanced
// - RF 4 and IR constant energy
// - RF 1,3,5,7 are PWM, 7 low duty
// - RF 1 is 33/66 ending high
// - RF 3 is 25/50 starting high
// - RF 5 is 33/66 starting high
// - IR formats modulate RF 4 differently
// - IR one two periods, zero three
// - Polarity 0 idles low
// - Polarity 1 idles high
// - Normal and sync frame kinds
// - Key press starts frames, repeat while held
// - Optional 80 s hold timeout halts
// - Normal frame 29 to 92 bits
// - Dynamic code, data, stop always sent
// - Fields, pause, timeout from configuration
// - Fixed field order
// - Fields sent MSB first
// - Data bits key1 to key4
// - Preamble once per press, fixed shape
module rolling_code_tx_line_encoder #(
   parameter int unsigned TIMEOUT_CYCLES = rc_tx_pkg::HOLD_TIMEOUT_CYCLES
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [3:0] keyswitch_input_n,
   output logic tx_pin,
   output logic rf_stage_enable_n,
   output logic oscillator_out_pin,
   output logic oscillator_out_oe
);
   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic code_lvl(input logic [3:0] f, input logic b,
                                     input logic [5:0] s);
      logic [11:0] m;
      m = rc_tx_pkg::IR_MASK[f[1:0]];
      case (f)
         rc_tx_pkg::FMT_RF0: code_lvl = b ^ (s < rc_tx_pkg::SUB_HALF);
         rc_tx_pkg::FMT_RF1: code_lvl = b ? (s >= rc_tx_pkg::SUB_THIRD)
                                          : (s >= rc_tx_pkg::SUB_2THIRD);
         rc_tx_pkg::FMT_RF2: code_lvl = b ? (s < rc_tx_pkg::SUB_HALF)
                                          : (s >= rc_tx_pkg::SUB_HALF);
         rc_tx_pkg::FMT_RF3: code_lvl = b ? (s < rc_tx_pkg::SUB_HALF)
                                          : (s < rc_tx_pkg::SUB_QTR);
         rc_tx_pkg::FMT_RF4: code_lvl = (s < rc_tx_pkg::SUBS);
         rc_tx_pkg::FMT_RF5: code_lvl = b ? (s < rc_tx_pkg::SUB_2THIRD)
                                          : (s < rc_tx_pkg::SUB_THIRD);
         rc_tx_pkg::FMT_RF7: code_lvl = b ? (s < rc_tx_pkg::SUB_LOW1)
                                          : (s < rc_tx_pkg::SUB_LOW0);
         default: code_lvl = f[3] && (s < rc_tx_pkg::SUBS)
                             && m[4'hB - s[3:0]];
      endcase
   endfunction : code_lvl

   // Formats with variable cell length: RF 4 and every IR format
   function automatic logic [5:0] cell_of(input logic [3:0] f,
                                          input rc_tx_pkg::kind_t k, input logic b);
      if (k != rc_tx_pkg::KIND_RAW && (f == rc_tx_pkg::FMT_RF4 || f[3]))
         cell_of = b ? rc_tx_pkg::CELL_IR_ONE : rc_tx_pkg::CELL_IR_ZERO;
      else
         cell_of = rc_tx_pkg::SUBS;
   endfunction : cell_of

   function automatic rc_tx_pkg::field_t first_on(input logic [2:0] from,
                                                  input rc_tx_pkg::ctrl_t c,
                                                  input logic pre);
      logic en;
      first_on = rc_tx_pkg::FLD_STOP;
      for (int i = 6; i >= 0; i--) begin
         case (i)
            0: en = pre;
            1: en = c.sync_en;
            2: en = c.keyid_en;
            5: en = c.parity_en;
            default: en = 1'b1;
         endcase
         if (3'(i) >= from && en)
            first_on = rc_tx_pkg::field_t'(3'(i));
      end
   endfunction : first_on

   // ****************************************
   // State
   // ****************************************
   rc_tx_pkg::ctrl_t cfg_r;
   logic [15:0] period_r, pause_r, div_r, pcnt_r;
   logic [23:0] keyid_r;
   logic [7:0] syncb_r, parity_r, frames_r;
   logic [39:0] dyn_r;
   logic [3:0] key_s1_r, key_s2_r, data_r;
   rc_tx_pkg::state_t st_r;
   rc_tx_pkg::field_t fld_r;
   logic [5:0] sub_r, bit_r;
   logic pre_pend_r;
   logic [31:0] tmo_r;
   logic key_held, fmt_bad, tick, cell_end, fld_end, cur_bit, lvl, hit;
   logic tmo_hit, pause_end;
   logic [5:0] fld_len, cell_len, idx;
   logic [39:0] fval;
   rc_tx_pkg::kind_t kind;
   logic [31:0] rd_mux;

   // ****************************************
   // Key synchroniser
   // ****************************************
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         key_s1_r <= 4'hF;
         key_s2_r <= 4'hF;
      end else begin
         key_s1_r <= keyswitch_input_n;
         key_s2_r <= key_s1_r;
      end
   end

   assign key_held = ~&key_s2_r;
   // Reserved selections never start a frame
   assign fmt_bad = (cfg_r.fmt == rc_tx_pkg::FMT_RSVD)
                    || (cfg_r.fmt[3] && cfg_r.fmt[2]);
   assign tmo_hit = cfg_r.hold_timeout_enable && (tmo_r >= TIMEOUT_CYCLES - 1);
   assign pause_end = tick && (pcnt_r >= pause_r);

   // ****************************************
   // Coding period divider
   // ****************************************
   // Free running: a frame starts without waiting for a tick, so its first sub-interval can be shorter than one period
   always_ff @(posedge clk) begin
      if (sys_rst || tick)
         div_r <= 16'h0000;
      else
         div_r <= div_r + 16'h0001;
   end
   assign tick = (div_r >= period_r - 16'h0001) || (period_r == 16'h0000);

   // ****************************************
   // Field and bit selection
   // ****************************************
   always_comb begin
      fval = 40'h0;
      case (fld_r)
         rc_tx_pkg::FLD_PRE: fld_len = rc_tx_pkg::LEN_PRE;
         rc_tx_pkg::FLD_SYNC: begin
            fld_len = rc_tx_pkg::LEN_BYTE;
            fval = {32'h0, syncb_r};
         end
         rc_tx_pkg::FLD_KEYID: begin
            fld_len = cfg_r.keyid24 ? rc_tx_pkg::LEN_KEYID_L : rc_tx_pkg::LEN_KEYID_S;
            fval = cfg_r.keyid24 ? {16'h0, keyid_r} : {20'h0, keyid_r[23:4]};
         end
         rc_tx_pkg::FLD_DATA: begin
            fld_len = rc_tx_pkg::LEN_DATA;
            fval = cfg_r.sync_mode ? 40'h0 : {36'h0, data_r};
         end
         rc_tx_pkg::FLD_DYN: begin
            fld_len = cfg_r.sync_mode ? rc_tx_pkg::LEN_START
                    : (cfg_r.dyn36 ? rc_tx_pkg::LEN_DYN_L : rc_tx_pkg::LEN_DYN_S);
            fval = dyn_r;
         end
         rc_tx_pkg::FLD_PAR: begin
            fld_len = rc_tx_pkg::LEN_BYTE;
            fval = {32'h0, parity_r};
         end
         default: begin
            fld_len = rc_tx_pkg::LEN_STOP;
            fval = 40'h1;
         end
      endcase
   end

   assign idx = 6'(fld_len - 6'h01 - bit_r);

   always_comb begin
      cur_bit = fval[idx];
      kind = rc_tx_pkg::KIND_CODED;
      if (fld_r == rc_tx_pkg::FLD_PRE) begin
         // Two high bit times, one low, then coded zeros
         cur_bit = (bit_r < 6'h02);
         if (bit_r < 6'h03)
            kind = rc_tx_pkg::KIND_RAW;
      end else if (fld_r == rc_tx_pkg::FLD_SYNC && cfg_r.sync_nrz)
         kind = rc_tx_pkg::KIND_NRZ;
   end

   always_comb begin
      cell_len = cell_of(cfg_r.fmt, kind, cur_bit);
      case (kind)
         rc_tx_pkg::KIND_RAW: lvl = cur_bit;
         // Format 7 keeps its low duty: NRZ one goes out as a zero level
         rc_tx_pkg::KIND_NRZ: lvl = (cfg_r.fmt == rc_tx_pkg::FMT_RF7)
                                    ? (!cur_bit && code_lvl(cfg_r.fmt, 1'b0, sub_r))
                                    : cur_bit;
         default: lvl = code_lvl(cfg_r.fmt, cur_bit, sub_r);
      endcase
   end

   assign cell_end = tick && (sub_r >= cell_len - 6'h01);
   assign fld_end = cell_end && (bit_r >= fld_len - 6'h01);

   // ****************************************
   // Frame sequencer
   // ****************************************
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st_r <= rc_tx_pkg::ST_IDLE;
         fld_r <= rc_tx_pkg::FLD_STOP;
         sub_r <= 6'h00;
         bit_r <= 6'h00;
         pcnt_r <= 16'h0000;
         pre_pend_r <= 1'b0;
         data_r <= 4'h0;
         frames_r <= 8'h00;
      end else if (tmo_hit && st_r != rc_tx_pkg::ST_HALT) begin
         st_r <= rc_tx_pkg::ST_HALT;
      end else begin
         unique case (st_r)
            rc_tx_pkg::ST_IDLE: begin
               if (key_held && !fmt_bad) begin
                  st_r <= rc_tx_pkg::ST_FRAME;
                  fld_r <= first_on(3'h0, cfg_r, cfg_r.preamble_en);
                  pre_pend_r <= cfg_r.preamble_en;
                  sub_r <= 6'h00;
                  bit_r <= 6'h00;
                  data_r <= ~{key_s2_r[0], key_s2_r[1], key_s2_r[2], key_s2_r[3]};
                  frames_r <= frames_r + 8'h01;
               end
            end
            rc_tx_pkg::ST_FRAME: begin
               if (tick)
                  sub_r <= cell_end ? 6'h00 : sub_r + 6'h01;
               if (cell_end)
                  bit_r <= fld_end ? 6'h00 : bit_r + 6'h01;
               if (fld_end) begin
                  if (fld_r == rc_tx_pkg::FLD_PRE)
                     pre_pend_r <= 1'b0;
                  if (fld_r == rc_tx_pkg::FLD_STOP) begin
                     st_r <= rc_tx_pkg::ST_PAUSE;
                     pcnt_r <= 16'h0000;
                  end else
                     fld_r <= first_on(3'(fld_r) + 3'h1, cfg_r, pre_pend_r);
               end
            end
            rc_tx_pkg::ST_PAUSE: begin
               if (tick)
                  pcnt_r <= pcnt_r + 16'h0001;
               if (pause_end) begin
                  if (key_held && !fmt_bad) begin
                     st_r <= rc_tx_pkg::ST_FRAME;
                     fld_r <= first_on(3'h1, cfg_r, 1'b0);
                     sub_r <= 6'h00;
                     bit_r <= 6'h00;
                     data_r <= ~{key_s2_r[0], key_s2_r[1], key_s2_r[2], key_s2_r[3]};
                     frames_r <= frames_r + 8'h01;
                  end else
                     st_r <= rc_tx_pkg::ST_IDLE;
               end
            end
            rc_tx_pkg::ST_HALT: begin
               // Halt ends only when every key is released
               if (!key_held)
                  st_r <= rc_tx_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Hold timer restarts whenever all keys are released
   always_ff @(posedge clk) begin
      if (sys_rst || !key_held)
         tmo_r <= 32'h0000_0000;
      else if (!tmo_hit)
         tmo_r <= tmo_r + 32'h0000_0001;
   end

   // ****************************************
   // Pins
   // ****************************************
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         tx_pin <= 1'b0;
         rf_stage_enable_n <= 1'b1;
         oscillator_out_pin <= 1'b1;
         oscillator_out_oe <= 1'b0;
      end else begin
         tx_pin <= (st_r == rc_tx_pkg::ST_FRAME) ? lvl : cfg_r.transmit_polarity;
         if (cfg_r.rc_clock || cfg_r.indicator_pin_select)
            rf_stage_enable_n <= (st_r != rc_tx_pkg::ST_FRAME);
         else
            rf_stage_enable_n <= (st_r != rc_tx_pkg::ST_PAUSE);
         oscillator_out_pin <= !(cfg_r.rc_clock && st_r == rc_tx_pkg::ST_PAUSE);
         // With a crystal the pin belongs to the oscillator
         oscillator_out_oe <= cfg_r.rc_clock;
      end
   end

   // ****************************************
   // APB slave, no wait states
   // ****************************************
   always_comb begin
      hit = 1'b1;
      case (paddr)
         rc_tx_pkg::ADDR_CTRL: rd_mux = {16'h0, cfg_r};
         rc_tx_pkg::ADDR_PERIOD: rd_mux = {16'h0, period_r};
         rc_tx_pkg::ADDR_PAUSE: rd_mux = {16'h0, pause_r};
         rc_tx_pkg::ADDR_KEYID: rd_mux = {8'h0, keyid_r};
         rc_tx_pkg::ADDR_SYNCPAR: rd_mux = {16'h0, parity_r, syncb_r};
         rc_tx_pkg::ADDR_DYN_LO: rd_mux = dyn_r[31:0];
         rc_tx_pkg::ADDR_DYN_HI: rd_mux = {24'h0, dyn_r[39:32]};
         rc_tx_pkg::ADDR_STATUS: rd_mux = {16'h0, frames_r, ~key_s2_r, fmt_bad,
                                           st_r == rc_tx_pkg::ST_HALT,
                                           st_r == rc_tx_pkg::ST_PAUSE,
                                           st_r == rc_tx_pkg::ST_FRAME};
         default: begin
            rd_mux = 32'h0000_0000;
            hit = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= psel && !penable && !pready;
         pslverr <= psel && !penable && !pready && !hit;
         prdata <= (psel && !penable && !pwrite) ? rd_mux : 32'h0000_0000;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cfg_r <= rc_tx_pkg::ctrl_t'(rc_tx_pkg::CTRL_RST);
         period_r <= rc_tx_pkg::PERIOD_RST;
         pause_r <= rc_tx_pkg::PAUSE_RST;
         keyid_r <= 24'h000000;
         syncb_r <= 8'h00;
         parity_r <= 8'h00;
         dyn_r <= 40'h00_0000_0000;
      end else if (psel && penable && pready && pwrite) begin
         case (paddr)
            rc_tx_pkg::ADDR_CTRL: cfg_r <= rc_tx_pkg::ctrl_t'(pwdata[15:0]);
            rc_tx_pkg::ADDR_PERIOD: period_r <= pwdata[15:0];
            rc_tx_pkg::ADDR_PAUSE: pause_r <= pwdata[15:0];
            rc_tx_pkg::ADDR_KEYID: keyid_r <= pwdata[23:0];
            rc_tx_pkg::ADDR_SYNCPAR: {parity_r, syncb_r} <= pwdata[15:0];
            rc_tx_pkg::ADDR_DYN_LO: dyn_r[31:0] <= pwdata;
            rc_tx_pkg::ADDR_DYN_HI: dyn_r[39:32] <= pwdata[7:0];
            default: ;
         endcase
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   AST_IDLE_PIN: assert property (
      (st_r == rc_tx_pkg::ST_IDLE) ##1 (st_r == rc_tx_pkg::ST_IDLE)
      |-> tx_pin == $past(cfg_r.transmit_polarity))
      else $error("tx pin not at idle level");
   AST_RF_EN: assert property (
      (st_r == rc_tx_pkg::ST_FRAME && cfg_r.rc_clock) |=> !rf_stage_enable_n)
      else $error("rf enable not active in frame");
   AST_IND_PAUSE: assert property (
      (st_r == rc_tx_pkg::ST_PAUSE && cfg_r.rc_clock) |=> !oscillator_out_pin
      && oscillator_out_oe)
      else $error("indicator not lit in pause");
   AST_XTAL_SEL0: assert property (
      (st_r == rc_tx_pkg::ST_PAUSE && !cfg_r.rc_clock && !cfg_r.indicator_pin_select)
      |=> !rf_stage_enable_n && !oscillator_out_oe)
      else $error("shared pin not indicator");
   AST_RESERVED: assert property (
      (st_r == rc_tx_pkg::ST_IDLE && fmt_bad && !tmo_hit) |=> st_r == rc_tx_pkg::ST_IDLE)
      else $error("reserved format started a frame");
   AST_KEY_START: assert property (
      (st_r == rc_tx_pkg::ST_IDLE && key_held && !fmt_bad && !tmo_hit)
      |=> st_r == rc_tx_pkg::ST_FRAME)
      else $error("key press did not start a frame");
   AST_REPEAT: assert property (
      (st_r == rc_tx_pkg::ST_PAUSE && pause_end && key_held && !fmt_bad && !tmo_hit)
      |=> st_r == rc_tx_pkg::ST_FRAME && fld_r != rc_tx_pkg::FLD_PRE)
      else $error("held key did not repeat");
   AST_TIMEOUT: assert property (
      (tmo_hit && st_r != rc_tx_pkg::ST_HALT) |=> st_r == rc_tx_pkg::ST_HALT)
      else $error("hold timeout did not halt");
   AST_STOP_LAST: assert property (
      (st_r == rc_tx_pkg::ST_FRAME) ##1 (st_r == rc_tx_pkg::ST_PAUSE)
      |-> $past(fld_r) == rc_tx_pkg::FLD_STOP)
      else $error("frame ended before stop bit");
   AST_PRE_ONCE: assert property (
      (st_r == rc_tx_pkg::ST_FRAME && fld_r == rc_tx_pkg::FLD_PRE) |-> pre_pend_r)
      else $error("preamble repeated");
   AST_IR_CELL: assert property (
      (st_r == rc_tx_pkg::ST_FRAME && cfg_r.fmt[3] && kind == rc_tx_pkg::KIND_CODED
      && cell_end) |-> sub_r == (cur_bit ? 6'h17 : 6'h23))
      else $error("IR cell length wrong");
   AST_MANCH: assert property (
      (st_r == rc_tx_pkg::ST_FRAME && cfg_r.fmt == rc_tx_pkg::FMT_RF0
      && kind == rc_tx_pkg::KIND_CODED && $stable(cfg_r))
      |=> tx_pin == ($past(cur_bit) ^ ($past(sub_r) < 6'h06)))
      else $error("format 0 not Manchester");
endmodule : rolling_code_tx_line_encoder
`default_nettype wire

// ==== tb/rc_tx_partner.sv ====
/* Far-side RF stage model: powered while the enable pin is low, it
   measures each burst (length and high cycles of the transmit line).
   Assumes the enable pin is active low and one clock domain. */
`default_nettype none
module rc_tx_partner (
   input wire logic clk,
   input wire logic tx_pin,
   input wire logic rf_stage_enable_n,
   output int len,
   output int high,
   output logic done
);
   timeunit 1ns;
   timeprecision 1ns;
   // ****
   // Burst meter
   // ****
   int l_r = 0;
   int h_r = 0;
   // Energy only counts while the stage is powered
   always @(posedge clk) begin
      done <= 1'b0;
      if (rf_stage_enable_n === 1'b0) begin
         l_r <= l_r + 1;
         h_r <= h_r + int'(tx_pin === 1'b1);
      end else if (l_r != 0) begin
         len <= l_r;
         high <= h_r;
         done <= 1'b1;
         l_r <= 0;
         h_r <= 0;
      end
   end
endmodule : rc_tx_partner
`default_nettype wire

// ==== tb/tb_top.sv ====
/* Bench of the rolling-code line encoder: APB tasks and frame checks.
   Assumes wait-free APB answers and PERIOD 1 (one sub-tick a clock). */
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic [3:0] key_n = 4'hF;
   logic [31:0] prdata, rd;
   logic pready, pslverr, pslv, tx_pin, rf_n, osc, osc_oe, done;
   int len, high, error_cnt = 0, comparisons = 0, cyc = 0;
   int h1[12] = '{6, 8, 6, 6, 12, 8, 0, 2, 6, 4, 8, 3};
   int h0[12] = '{6, 4, 6, 3, 12, 4, 0, 1, 6, 4, 8, 3};
   always #50 clk = ~clk;
   rolling_code_tx_line_encoder #(.TIMEOUT_CYCLES(2000)) i_rolling_code_tx_line_encoder (
      .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .keyswitch_input_n(key_n), .tx_pin(tx_pin), .rf_stage_enable_n(rf_n),
      .oscillator_out_pin(osc), .oscillator_out_oe(osc_oe));
   rc_tx_partner i_rc_tx_partner (.clk(clk), .tx_pin(tx_pin), .rf_stage_enable_n(rf_n),
      .len(len), .high(high), .done(done));
   // ****
   // Tasks
   // ****
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      pslv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // Press key 1 until one burst ends, then let the pause run out
   task automatic frame();
      key_n <= 4'hE;
      @(posedge done);
      key_n <= 4'hF;
      repeat (60) @(posedge clk);
   endtask : frame
   task automatic summarize();
      $display("Comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : summarize
   // Hang guard; the format sweep alone needs about 15000 cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 80000) begin
         error_cnt++;
         summarize();
      end
   end
   // ****
   // Tests
   // ****
   initial begin
      int ones;
      repeat (16) @(posedge clk);
      sys_rst <= 1'b0;
      apb(1'b0, rc_tx_pkg::ADDR_PERIOD, 32'h0);
      chk("period", {16'h0000, rc_tx_pkg::PERIOD_RST}, rd);
      apb(1'b0, rc_tx_pkg::ADDR_PAUSE, 32'h0);
      chk("pause", {16'h0000, rc_tx_pkg::PAUSE_RST}, rd);
      apb(1'b0, 8'h40, 32'h0);
      chk("unmapped", 32'h1, {31'h0, pslv});
      chk("idle low", 32'h0, {31'h0, tx_pin});
      apb(1'b1, rc_tx_pkg::ADDR_PERIOD, 32'h1);
      apb(1'b1, rc_tx_pkg::ADDR_PAUSE, 32'h10);
      $display("Test registers done");
      for (int f = 0; f < 12; f++) begin
         for (int v = 0; v < 2 && f != 6; v++) begin
            apb(1'b1, rc_tx_pkg::ADDR_DYN_LO, v ? 32'h00FFFFFF : 32'h0);
            apb(1'b1, rc_tx_pkg::ADDR_CTRL, 32'h20 | f);
            frame();
            ones = v ? 26 : 2;
            chk("len", f == 4 || f > 7 ? ones * 24 + (29 - ones) * 36 : 348, len);
            chk("high", ones * h1[f] + (29 - ones) * h0[f], high);
         end
      end
      $display("Test formats done");
      foreach (h1[i]) if (i == 6 || i == 8) begin
         apb(1'b1, rc_tx_pkg::ADDR_CTRL, i == 6 ? 32'h26 : 32'h2C);
         key_n <= 4'hE;
         repeat (300) @(posedge clk);
         chk("reserved idle", 32'h1, {31'h0, rf_n});
         apb(1'b0, rc_tx_pkg::ADDR_STATUS, 32'h0);
         chk("reserved flag", 32'h8, rd & 32'h8);
         key_n <= 4'hF;
      end
      apb(1'b1, rc_tx_pkg::ADDR_CTRL, 32'h40);
      frame();
      chk("rc lamp", 32'h1, {31'h0, osc_oe});
      chk("rc burst", 32'd348, len);
      apb(1'b1, rc_tx_pkg::ADDR_CTRL, 32'h00);
      frame();
      chk("lamp in pause", 32'h1, {31'h0, len > 10 && len < 40});
      // The burst seen here is a pause, so the key was held into a repeat frame
      repeat (400) @(posedge clk);
      apb(1'b1, rc_tx_pkg::ADDR_CTRL, 32'h30);
      repeat (4) @(posedge clk);
      chk("idle high", 32'h1, {31'h0, tx_pin});
      $display("Test pins done");
      apb(1'b1, rc_tx_pkg::ADDR_CTRL, 32'hA0);
      key_n <= 4'hE;
      repeat (2600) @(posedge clk);
      apb(1'b0, rc_tx_pkg::ADDR_STATUS, 32'h0);
      chk("halt", 32'h4, rd & 32'h4);
      chk("halt stage off", 32'h1, {31'h0, rf_n});
      key_n <= 4'hF;
      $display("Test timeout done");
      summarize();
   end
endmodule : tb_top
`default_nettype wire
